// ==== core/ssb_pkg.sv ====
/*
 * Shared constants and carrier types for the digital audio interface
 * status and user-bit buffer register bank.
 * Assumes a byte-wide register port already decoded from the serial
 * control interface, and a single device clock.
 */
package ssb_pkg;

    // ************************************************************
    // Sizes.
    // ************************************************************
    localparam int SSB_ADDR_W = 7;          // Register address width.
    localparam int SSB_CS_BYTES = 24;       // Channel status bytes per buffer.
    localparam int SSB_CS_IDX_W = 5;        // Index width for a status byte.
    localparam int SSB_UB_BYTES = 256;      // User-bit buffer bytes.
    localparam int SSB_UB_IDX_W = 8;        // Indirect pointer width.
    localparam int SSB_AUDIO_W = 24;        // Transmit audio word width.

    typedef logic [7:0] ssb_byte_t;
    typedef logic [SSB_ADDR_W-1:0] ssb_addr_t;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam ssb_addr_t SSB_ADDR_MUTE_DEEM = 7'h1e;
    localparam ssb_addr_t SSB_ADDR_PAYLOAD = 7'h1f;
    localparam ssb_addr_t SSB_ADDR_RXCS_FIRST = 7'h20;
    localparam ssb_addr_t SSB_ADDR_RXCS_LAST = 7'h37;
    localparam ssb_addr_t SSB_ADDR_TXCS_FIRST = 7'h38;
    localparam ssb_addr_t SSB_ADDR_TXCS_LAST = 7'h4f;
    localparam ssb_addr_t SSB_ADDR_RXUB_PTR = 7'h50;
    localparam ssb_addr_t SSB_ADDR_RXUB_DATA = 7'h51;
    localparam ssb_addr_t SSB_ADDR_TXUB_PTR = 7'h52;
    localparam ssb_addr_t SSB_ADDR_TXUB_DATA = 7'h53;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int SSB_MUTE_BIT = 5;        // Transmit silence control.
    localparam int SSB_DEEM_LSB = 1;        // De-emphasis select, bits 2:1.
    localparam int SSB_FLAG_PREAMBLE = 3;   // Surround CD preamble seen.
    localparam int SSB_FLAG_FRAME = 2;      // Frame non-PCM.
    localparam int SSB_FLAG_SUB_A = 1;      // Channel A subframe non-audio.
    localparam int SSB_FLAG_SUB_B = 0;      // Channel B subframe non-audio.
    localparam int SSB_PRO_BIT = 0;         // Professional format flag in byte 0.
    localparam int SSB_PRO_BYTE = 0;        // Status byte that holds that flag.
    localparam ssb_byte_t SSB_BYTE_ZERO = 8'h00;

    // De-emphasis selections.
    typedef enum logic [1:0] {
        SSB_DEEM_NONE = 2'h0,
        SSB_DEEM_32K = 2'h1,
        SSB_DEEM_44K1 = 2'h2,
        SSB_DEEM_48K = 2'h3
    } ssb_deem_t;

    // ************************************************************
    // Carriers.
    // ************************************************************
    // One host register access, already decoded from the serial port.
    typedef struct packed {
        logic wr;
        logic rd;
        ssb_addr_t addr;
        ssb_byte_t wdata;
    } ssb_host_req_t;

    // Detector levels from the receiver.
    typedef struct packed {
        logic preamble;
        logic consumer_nonaudio;
        logic broadcast_nonaudio;
        logic sub_a_nonaudio;
        logic sub_b_nonaudio;
    } ssb_rx_det_t;

    // Receiver writes into its status and user-bit buffers.
    typedef struct packed {
        logic cs_we;
        logic [SSB_CS_IDX_W-1:0] cs_idx;
        logic ub_we;
        logic [SSB_UB_IDX_W-1:0] ub_idx;
        ssb_byte_t data;
    } ssb_rx_wr_t;

    // Whole state of the register bank.
    typedef struct packed {
        logic mute;
        ssb_deem_t deem;
        logic [3:0] flags;
        ssb_byte_t [SSB_CS_BYTES-1:0] rx_cs;
        ssb_byte_t [SSB_CS_BYTES-1:0] tx_cs;
        ssb_byte_t [SSB_UB_BYTES-1:0] rx_ub;
        ssb_byte_t [SSB_UB_BYTES-1:0] tx_ub;
        ssb_byte_t rx_ptr;
        ssb_byte_t tx_ptr;
        ssb_byte_t rdata;
        logic rvalid;
        logic [SSB_AUDIO_W-1:0] audio;
        ssb_byte_t tx_cs_byte;
        ssb_byte_t tx_ub_byte;
        logic rx_pro;
        logic tx_pro;
    } ssb_state_t;

endpackage

// ==== core/ssb_bank.sv ====
/*
 * Register bank of the digital audio interface: transmit silence and
 * rate converter de-emphasis control, receiver payload-type flags,
 * receive and transmit channel status buffers and the indirect ports
 * into the receive and transmit user-bit buffers.
 * Assumes host accesses arrive as single-cycle strobes on the device
 * clock, and that autobuffering enables come from a register elsewhere.
 */
// What this block does
// - Two-bit select picks rate converter de-emphasis.
// - Frame non-PCM flag under either standard.
// - Receive status buffer, 24 bytes at 0x20-0x37.
// - Received professional flag is byte 0 bit 0.
// - Receive status readable only without autobuffering.
// - Transmit status buffer, 24 bytes at 0x38-0x4F.
// - Transmitted professional flag from byte 0 bit 0.
// - Status autobuffering blocks host transmit status access.
// - Pointer at 0x50 selects receive user byte.
// - Read 0x51 returns pointed receive user byte.
// - Host writes receive user bytes only when autobuffering.
// - Pointer at 0x52 selects transmit user byte.
// - Write 0x53 stores pointed transmit user byte.
// - User autobuffering disables host transmit user buffer.
`timescale 1ns/1ns
`default_nettype none

module ssb_bank (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Host register port.
    input wire ssb_pkg::ssb_host_req_t host_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Autobuffering enables held elsewhere.
    input wire logic cs_autobuf_in,
    input wire logic ub_autobuf_in,
    // Receiver side.
    input wire ssb_pkg::ssb_rx_det_t rx_det_in,
    input wire ssb_pkg::ssb_rx_wr_t rx_wr_in,
    output logic rx_pro_out,
    // Transmitter side.
    input wire logic [ssb_pkg::SSB_AUDIO_W-1:0] tx_audio_in,
    output logic [ssb_pkg::SSB_AUDIO_W-1:0] tx_audio_out,
    input wire logic [ssb_pkg::SSB_CS_IDX_W-1:0] tx_cs_idx_in,
    output logic [7:0] tx_cs_byte_out,
    input wire logic [ssb_pkg::SSB_UB_IDX_W-1:0] tx_ub_idx_in,
    output logic [7:0] tx_ub_byte_out,
    output logic tx_pro_out,
    // Rate converter.
    output logic [1:0] rate_conv_deemph_sel_out
);
    import ssb_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    ssb_state_t state_r;    // Every flip-flop of the bank.
    ssb_state_t state_nxt;  // Next value of the bank.

    // Address decode helpers.
    logic in_rxcs;          // Access falls inside the receive status buffer.
    logic in_txcs;          // Access falls inside the transmit status buffer.
    logic [SSB_CS_IDX_W-1:0] rxcs_idx;  // Byte index in receive status.
    logic [SSB_CS_IDX_W-1:0] txcs_idx;  // Byte index in transmit status.
    ssb_addr_t rxcs_off;    // Offset from the receive buffer base.
    ssb_addr_t txcs_off;    // Offset from the transmit buffer base.

    // ************************************************************
    // Address decode.
    // ************************************************************
    // Buffer windows are decoded once so read and write agree.
    always_comb begin
        in_rxcs = (host_req_in.addr >= SSB_ADDR_RXCS_FIRST) &&
                  (host_req_in.addr <= SSB_ADDR_RXCS_LAST);
        in_txcs = (host_req_in.addr >= SSB_ADDR_TXCS_FIRST) &&
                  (host_req_in.addr <= SSB_ADDR_TXCS_LAST);
        rxcs_off = host_req_in.addr - SSB_ADDR_RXCS_FIRST;
        txcs_off = host_req_in.addr - SSB_ADDR_TXCS_FIRST;
        rxcs_idx = rxcs_off[SSB_CS_IDX_W-1:0];
        txcs_idx = txcs_off[SSB_CS_IDX_W-1:0];
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    // Receiver writes land first; a host write to the same byte in the
    // same cycle is applied after, so the host value is the one kept.
    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = 1'b0;

        // Receiver detector levels are sampled every cycle.
        state_nxt.flags[SSB_FLAG_PREAMBLE] = rx_det_in.preamble;
        state_nxt.flags[SSB_FLAG_FRAME] = rx_det_in.consumer_nonaudio |
                                          rx_det_in.broadcast_nonaudio;
        state_nxt.flags[SSB_FLAG_SUB_A] = rx_det_in.sub_a_nonaudio;
        state_nxt.flags[SSB_FLAG_SUB_B] = rx_det_in.sub_b_nonaudio;

        // The receiver fills its own buffers; out-of-range indices drop.
        if (rx_wr_in.cs_we && (32'(rx_wr_in.cs_idx) < SSB_CS_BYTES)) begin
            state_nxt.rx_cs[rx_wr_in.cs_idx] = rx_wr_in.data;
        end
        if (rx_wr_in.ub_we) begin
            state_nxt.rx_ub[rx_wr_in.ub_idx] = rx_wr_in.data;
        end

        // Host writes.
        if (host_req_in.wr) begin
            if (host_req_in.addr == SSB_ADDR_MUTE_DEEM) begin
                state_nxt.mute = host_req_in.wdata[SSB_MUTE_BIT];
                state_nxt.deem = ssb_deem_t'(host_req_in.wdata[SSB_DEEM_LSB +: 2]);
            end else if (in_txcs) begin
                // Autobuffering owns the transmit status; host is shut out.
                if (!cs_autobuf_in) begin
                    state_nxt.tx_cs[txcs_idx] = host_req_in.wdata;
                end
            end else if (host_req_in.addr == SSB_ADDR_RXUB_PTR) begin
                state_nxt.rx_ptr = host_req_in.wdata;
            end else if (host_req_in.addr == SSB_ADDR_RXUB_DATA) begin
                // Writable only while user bits are autobuffered.
                if (ub_autobuf_in) begin
                    state_nxt.rx_ub[state_r.rx_ptr] = host_req_in.wdata;
                end
            end else if (host_req_in.addr == SSB_ADDR_TXUB_PTR) begin
                state_nxt.tx_ptr = host_req_in.wdata;
            end else if (host_req_in.addr == SSB_ADDR_TXUB_DATA) begin
                // The host-fed transmit buffer is out of use when autobuffering.
                if (!ub_autobuf_in) begin
                    state_nxt.tx_ub[state_r.tx_ptr] = host_req_in.wdata;
                end
            end else begin
                // Read-only and unmapped addresses ignore writes.
                state_nxt.mute = state_r.mute;
            end
        end

        // Host reads answer one cycle later; unmapped reads give zero.
        if (host_req_in.rd) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rdata = SSB_BYTE_ZERO;
            if (host_req_in.addr == SSB_ADDR_MUTE_DEEM) begin
                state_nxt.rdata[SSB_MUTE_BIT] = state_r.mute;
                state_nxt.rdata[SSB_DEEM_LSB +: 2] = state_r.deem;
            end else if (host_req_in.addr == SSB_ADDR_PAYLOAD) begin
                state_nxt.rdata[SSB_FLAG_PREAMBLE:SSB_FLAG_SUB_B] = state_r.flags;
            end else if (in_rxcs) begin
                // Hidden while the receiver forwards status to the transmitter.
                if (!cs_autobuf_in) begin
                    state_nxt.rdata = state_r.rx_cs[rxcs_idx];
                end
            end else if (in_txcs) begin
                if (!cs_autobuf_in) begin
                    state_nxt.rdata = state_r.tx_cs[txcs_idx];
                end
            end else if (host_req_in.addr == SSB_ADDR_RXUB_PTR) begin
                state_nxt.rdata = state_r.rx_ptr;
            end else if (host_req_in.addr == SSB_ADDR_RXUB_DATA) begin
                state_nxt.rdata = state_r.rx_ub[state_r.rx_ptr];
            end else if (host_req_in.addr == SSB_ADDR_TXUB_PTR) begin
                state_nxt.rdata = state_r.tx_ptr;
            end else begin
                // Transmit data port is write-only and reads as zero.
                state_nxt.rdata = SSB_BYTE_ZERO;
            end
        end

        // Transmit audio is forced to digital silence while muted.
        state_nxt.audio = state_r.mute ? '0 : tx_audio_in;

        // With autobuffering the transmitter is fed from the receiver side.
        if (cs_autobuf_in) begin
            state_nxt.tx_cs_byte = state_r.rx_cs[tx_cs_idx_in];
            state_nxt.tx_pro = state_r.rx_cs[SSB_PRO_BYTE][SSB_PRO_BIT];
        end else begin
            state_nxt.tx_cs_byte = state_r.tx_cs[tx_cs_idx_in];
            state_nxt.tx_pro = state_r.tx_cs[SSB_PRO_BYTE][SSB_PRO_BIT];
        end
        if (ub_autobuf_in) begin
            state_nxt.tx_ub_byte = state_r.rx_ub[tx_ub_idx_in];
        end else begin
            state_nxt.tx_ub_byte = state_r.tx_ub[tx_ub_idx_in];
        end
        state_nxt.rx_pro = state_r.rx_cs[SSB_PRO_BYTE][SSB_PRO_BIT];
    end

    // ************************************************************
    // State register.
    // ************************************************************
    // Everything clears to zero: unmuted, no de-emphasis, empty buffers.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Outputs, each straight from the state register.
    // ************************************************************
    assign reg_rdata_out = state_r.rdata;
    assign reg_rvalid_out = state_r.rvalid;
    assign rate_conv_deemph_sel_out = state_r.deem;
    assign tx_audio_out = state_r.audio;
    assign tx_cs_byte_out = state_r.tx_cs_byte;
    assign tx_ub_byte_out = state_r.tx_ub_byte;
    assign rx_pro_out = state_r.rx_pro;
    assign tx_pro_out = state_r.tx_pro;

    // ************************************************************
    // Checks.
    // ************************************************************
    // A mute write followed by audio: silence two edges later.
    sequence s_mute_write;
        host_req_in.wr && host_req_in.addr == SSB_ADDR_MUTE_DEEM &&
            host_req_in.wdata[SSB_MUTE_BIT];
    endsequence

    a_mute_silences: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_mute_write |=> ##1 (tx_audio_out == '0))
        else $error("audio not silenced after mute write");

    a_deem_follows: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        host_req_in.wr && host_req_in.addr == SSB_ADDR_MUTE_DEEM |=>
            rate_conv_deemph_sel_out == $past(host_req_in.wdata[SSB_DEEM_LSB +: 2]))
        else $error("de-emphasis select did not follow write");

    a_frame_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rx_det_in.consumer_nonaudio || rx_det_in.broadcast_nonaudio) |=>
            state_r.flags[SSB_FLAG_FRAME])
        else $error("frame non-PCM flag missing");

    a_payload_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        host_req_in.rd && host_req_in.addr == SSB_ADDR_PAYLOAD |=>
            reg_rvalid_out && reg_rdata_out[7:4] == 4'h0 &&
            reg_rdata_out[SSB_FLAG_PREAMBLE] == $past(state_r.flags[SSB_FLAG_PREAMBLE]))
        else $error("payload flag read wrong");

    a_rxcs_hidden: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        host_req_in.rd && in_rxcs && cs_autobuf_in |=> reg_rdata_out == SSB_BYTE_ZERO)
        else $error("receive status visible during autobuffering");

    a_txcs_locked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        host_req_in.wr && in_txcs && cs_autobuf_in |=>
            state_r.tx_cs[$past(txcs_idx)] == $past(state_r.tx_cs[txcs_idx]))
        else $error("transmit status written during autobuffering");

    a_pro_source: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !cs_autobuf_in |=> tx_pro_out == $past(state_r.tx_cs[SSB_PRO_BYTE][SSB_PRO_BIT]))
        else $error("transmit professional flag from wrong byte");

    // Pointer load, one cycle with no other pointer load, then a data write:
    // the pointed byte takes the data. The idle cycle matches a host that
    // drops its strobe between accesses.
    sequence s_txub_load;
        host_req_in.wr && host_req_in.addr == SSB_ADDR_TXUB_PTR ##1
            !(host_req_in.wr && host_req_in.addr == SSB_ADDR_TXUB_PTR) ##1
            host_req_in.wr && host_req_in.addr == SSB_ADDR_TXUB_DATA && !ub_autobuf_in;
    endsequence

    a_txub_store: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_txub_load |=> state_r.tx_ub[$past(host_req_in.wdata, 3)] ==
            $past(host_req_in.wdata))
        else $error("transmit user byte not stored at pointer");

    a_rxub_readonly: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        host_req_in.wr && host_req_in.addr == SSB_ADDR_RXUB_DATA && !ub_autobuf_in &&
            !rx_wr_in.ub_we |=> $stable(state_r.rx_ub))
        else $error("receive user buffer written while read-only");

    a_rxub_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        host_req_in.rd && host_req_in.addr == SSB_ADDR_RXUB_DATA |=>
            reg_rdata_out == $past(state_r.rx_ub[state_r.rx_ptr]))
        else $error("receive user read returned wrong byte");

endmodule

`default_nettype wire

// ==== tb/ssb_host_model.sv ====
/*
 * Host controller model for the register bank: single register
 * writes and reads, plus pointer-then-data access to the user-bit ports.
 * Assumes the bank takes a strobe at a rising edge and answers a read
 * with a one-cycle valid pulse registered on that same edge.
 */
`timescale 1ns/1ns
`default_nettype none

module ssb_host_model (
    // Clock.
    input wire logic ref_clk_in,
    // Register port.
    output var ssb_pkg::ssb_host_req_t req_out,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in
);
    import ssb_pkg::*;

    // Idle port from time zero, so that no strobe is seen during reset.
    initial begin
        req_out = '0;
    end

    // One write strobe, held over exactly one taking edge.
    task automatic write_reg(input ssb_addr_t a, input ssb_byte_t d);
        @(posedge ref_clk_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_in);
        req_out.wr <= 1'b0;
    endtask

    // One read strobe. The valid pulse lasts one cycle, so it is looked
    // at just after the answering edge; a missing pulse gives unknowns.
    task automatic read_reg(input ssb_addr_t a, output ssb_byte_t d);
        @(posedge ref_clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk_in);
        req_out.rd <= 1'b0;
        #1;
        d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
    endtask

    // The pointer never advances by itself, so it is loaded every time.
    task automatic read_indirect(input ssb_addr_t pa, input ssb_byte_t p,
                                 input ssb_addr_t da, output ssb_byte_t d);
        write_reg(pa, p);
        read_reg(da, d);
    endtask
endmodule

`default_nettype wire

// ==== tb/spdif_status_user_buffers_tb_top.sv ====
/*
 * Self-checking testbench of the status and user-bit register bank.
 * Assumes the host model drives the register port and that this module
 * plays receiver, transmitter and the autobuffering enables.
 */
`timescale 1ns/1ns
`default_nettype none

module spdif_status_user_buffers_tb_top;
    import ssb_pkg::*;

    // ************************************************************
    // Signals.
    // ************************************************************
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    ssb_host_req_t host_req; // Driven by the host model.
    logic [7:0] rdata;
    logic rvalid;
    logic cs_ab = 1'b0; // Status autobuffering enable.
    logic ub_ab = 1'b0; // User-bit autobuffering enable.
    ssb_rx_det_t det = '0;
    ssb_rx_wr_t rxw = '0;
    logic [23:0] audio_in = 24'h12_3456;
    logic [23:0] audio_out;
    logic [4:0] cs_idx = 5'h00;
    logic [7:0] ub_idx = 8'h00;
    logic [7:0] cs_byte;
    logic [7:0] ub_byte;
    logic rx_pro;
    logic tx_pro;
    logic [1:0] deem;
    ssb_byte_t rd;
    int errors = 0;
    int comparisons = 0;
    // Flag register images for the one-hot detector walk.
    logic [7:0] fexp [5] = '{8'h08, 8'h04, 8'h04, 8'h02, 8'h01};

    // Free-running 50 MHz clock.
    always #10 ref_clk_in = ~ref_clk_in;

    ssb_host_model host (
        .ref_clk_in(ref_clk_in),
        .req_out(host_req),
        .rdata_in(rdata),
        .rvalid_in(rvalid)
    );

    ssb_bank DUT (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .host_req_in(host_req),
        .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid),
        .cs_autobuf_in(cs_ab),
        .ub_autobuf_in(ub_ab),
        .rx_det_in(det),
        .rx_wr_in(rxw),
        .rx_pro_out(rx_pro),
        .tx_audio_in(audio_in),
        .tx_audio_out(audio_out),
        .tx_cs_idx_in(cs_idx),
        .tx_cs_byte_out(cs_byte),
        .tx_ub_idx_in(ub_idx),
        .tx_ub_byte_out(ub_byte),
        .tx_pro_out(tx_pro),
        .rate_conv_deemph_sel_out(deem)
    );

    // ************************************************************
    // Tasks.
    // ************************************************************
    // Compares with case equality so an unknown never passes.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input ssb_addr_t a, input ssb_byte_t e);
        host.read_reg(a, rd);
        check(rd, e);
    endtask

    // Lets n edges pass, then steps off the edge so outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    // One receiver write pulse into the status or the user-bit buffer.
    task automatic rx_put(input logic cs, input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk_in);
        rxw <= '{cs_we: cs, cs_idx: idx[4:0], ub_we: !cs, ub_idx: idx, data: d};
        @(posedge ref_clk_in);
        rxw <= '0;
    endtask

    task automatic set_ab(input logic cs, input logic ub);
        @(posedge ref_clk_in);
        cs_ab <= cs;
        ub_ab <= ub;
    endtask

    task automatic report_and_stop;
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Tests.
    // ************************************************************
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rchk(SSB_ADDR_MUTE_DEEM, 8'h00);
        rchk(SSB_ADDR_PAYLOAD, 8'h00);
        // Every select code, written with all reserved bits set.
        for (int i = 0; i < 4; i++) begin
            host.write_reg(SSB_ADDR_MUTE_DEEM, 8'hd9 | 8'(i << 1));
            rchk(SSB_ADDR_MUTE_DEEM, 8'(i << 1));
            check(deem, i[1:0]);
        end
        // Silence and release the transmitter.
        host.write_reg(SSB_ADDR_MUTE_DEEM, 8'h20);
        tick(2);
        check(audio_out, 24'h00_0000);
        host.write_reg(SSB_ADDR_MUTE_DEEM, 8'h00);
        tick(2);
        check(audio_out, 24'h12_3456);
        // Walk one detector at a time; flags follow the levels.
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk_in);
            det <= ssb_rx_det_t'(5'h10 >> i);
            tick(2);
            rchk(SSB_ADDR_PAYLOAD, fexp[i]);
        end
        @(posedge ref_clk_in);
        det <= '0;
        tick(2);
        rchk(SSB_ADDR_PAYLOAD, 8'h00);
        // Receive status: first and last byte, host write refused.
        rx_put(1'b1, 8'h00, 8'h01);
        rx_put(1'b1, 8'h17, 8'h5a);
        host.write_reg(SSB_ADDR_RXCS_FIRST, 8'hff);
        rchk(SSB_ADDR_RXCS_FIRST, 8'h01);
        rchk(SSB_ADDR_RXCS_LAST, 8'h5a);
        check(rx_pro, 1'b1);
        // Autobuffering hides receive status from host reads and refuses transmit status writes.
        set_ab(1'b1, 1'b0);
        rchk(SSB_ADDR_RXCS_FIRST, 8'h00);
        host.write_reg(SSB_ADDR_TXCS_FIRST, 8'h03);
        set_ab(1'b0, 1'b0);
        rchk(SSB_ADDR_TXCS_FIRST, 8'h00);
        host.write_reg(SSB_ADDR_TXCS_FIRST, 8'h03);
        host.write_reg(SSB_ADDR_TXCS_LAST, 8'hc3);
        rchk(SSB_ADDR_TXCS_LAST, 8'hc3);
        tick(2);
        check(cs_byte, 8'h03);
        check(tx_pro, 1'b1);
        @(posedge ref_clk_in);
        cs_idx <= 5'h17;
        tick(2);
        check(cs_byte, 8'hc3);
        set_ab(1'b1, 1'b0);
        tick(2);
        check(cs_byte, 8'h5a);
        set_ab(1'b0, 1'b0);
        // Receive user bits through the indirect port.
        rx_put(1'b0, 8'h07, 8'h77);
        host.read_indirect(SSB_ADDR_RXUB_PTR, 8'h07, SSB_ADDR_RXUB_DATA, rd);
        check(rd, 8'h77);
        rchk(SSB_ADDR_RXUB_PTR, 8'h07);
        host.write_reg(SSB_ADDR_RXUB_DATA, 8'h99);
        host.read_indirect(SSB_ADDR_RXUB_PTR, 8'h07, SSB_ADDR_RXUB_DATA, rd);
        check(rd, 8'h77);
        set_ab(1'b0, 1'b1);
        host.write_reg(SSB_ADDR_RXUB_DATA, 8'h99);
        host.read_indirect(SSB_ADDR_RXUB_PTR, 8'h07, SSB_ADDR_RXUB_DATA, rd);
        check(rd, 8'h99);
        // Transmit user bits: refused while autobuffering, then stored.
        host.write_reg(SSB_ADDR_TXUB_PTR, 8'h05);
        host.write_reg(SSB_ADDR_TXUB_DATA, 8'haa);
        set_ab(1'b0, 1'b0);
        ub_idx <= 8'h05;
        tick(2);
        check(ub_byte, 8'h00);
        host.write_reg(SSB_ADDR_TXUB_PTR, 8'h05);
        host.write_reg(SSB_ADDR_TXUB_DATA, 8'haa);
        tick(2);
        check(ub_byte, 8'haa);
        rchk(SSB_ADDR_TXUB_PTR, 8'h05);
        rchk(SSB_ADDR_TXUB_DATA, 8'h00);
        set_ab(1'b0, 1'b1);
        tick(2);
        check(ub_byte, 8'h00);
        rchk(7'h7f, 8'h00);
        report_and_stop();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #200_000;
        errors++;
        report_and_stop();
    end
endmodule

`default_nettype wire
